/* File: hdl/scsp_cfg.svh */
// offsets, field positions, reset values and divide counts for the clock control block
// Operation
// - slow source: crystal 0, rc 1; fast mode only
// - crystal gain field 3 highest, resets 11
// - idle stop bit gates peripheral clocks in idle
// - fast stop bit halts fast clock when slow/idle; the code halts it only once the divider is off the fast source
// - fast stop bit changes only in slow mode
// - system select: slow 0, fast 1; needs stop 0
// - prescaler codes 00..11 divide 64,16,4,1
// - rc stop bit halts rc oscillator
`ifndef SCSP_CFG_SVH
`define SCSP_CFG_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define SCSP_CTRL_ADR 8'hd8
`define SCSP_AUX_ADR 8'hf8

// ************************************************************
// clock control register fields
// ************************************************************
`define SCSP_SLOW_SEL_BIT 7
`define SCSP_GAIN_HI 6
`define SCSP_GAIN_LO 5
`define SCSP_PSTOP_BIT 4
`define SCSP_FSTOP_BIT 3
`define SCSP_SYSSEL_BIT 2
`define SCSP_PSC_HI 1
`define SCSP_PSC_LO 0
`define SCSP_CTRL_RST 8'h67

// ************************************************************
// auxiliary control register fields
// ************************************************************
`define SCSP_RCSTOP_BIT 1
`define SCSP_AUX_RST 8'h00

// ************************************************************
// prescaler half periods, counted in source edges, minus one
// ************************************************************
`define SCSP_HALF_DIV64 6'h3f
`define SCSP_HALF_DIV16 6'h0f
`define SCSP_HALF_DIV4 6'h03
`define SCSP_HALF_DIV1 6'h00

`endif

/* File: hdl/scsp_pkg.sv */
// types shared by the clock control block
package scsp_pkg;
    // prescaler field encoding
    typedef enum logic [1:0] {
        SCSP_DIV64,
        SCSP_DIV16,
        SCSP_DIV4,
        SCSP_DIV1
    } scsp_psc_t;
    // output clock phase tracker
    typedef enum logic {
        SCSP_PH_LOW,
        SCSP_PH_HIGH
    } scsp_phase_t;
endpackage

/* File: hdl/scsp_top.sv */
// system clock select, prescaler and oscillator stop control with wishbone registers
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "scsp_cfg.svh"

module scsp_top
    import scsp_pkg::*;
#(
    parameter int AW = 8 // wishbone address width
) (
    input wire logic clk_i, // 125 mhz block clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write enable
    input wire logic [AW-1:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    input wire logic idle_i, // core is in idle mode
    input wire logic fast_osc_i, // fast oscillator clock pin
    input wire logic xtal_osc_i, // crystal oscillator clock pin
    input wire logic rc_osc_i, // rc oscillator clock pin
    output logic sys_clk_o, // divided system clock
    output logic periph_clk_en_o, // peripheral clock enable
    output logic fast_osc_en_o, // fast oscillator run
    output logic rc_osc_en_o, // rc oscillator run
    output logic [1:0] crystal_gain_o, // crystal amplifier gain
    output logic slow_source_select_o // active slow source
);

    // ************************************************************
    // oscillator input synchronisers
    // ************************************************************
    logic [2:0] osc_s1_r; // first stage, read only by second
    logic [2:0] osc_s2_r; // second stage, usable
    logic [2:0] osc_s1_nxt;
    logic [2:0] osc_s2_nxt;

    // sample pins; the source clocks are far slower than clk_i
    always_comb begin
        osc_s1_nxt = {rc_osc_i, xtal_osc_i, fast_osc_i};
        osc_s2_nxt = osc_s1_r;
    end

    // synchroniser flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s1_r <= 3'h0;
            osc_s2_r <= 3'h0;
        end else begin
            osc_s1_r <= osc_s1_nxt;
            osc_s2_r <= osc_s2_nxt;
        end
    end

    // ************************************************************
    // register file and wishbone slave
    // ************************************************************
    logic slow_sel_r; // slow source select
    logic [1:0] gain_r; // crystal gain
    logic pstop_r; // idle peripheral clock stop
    logic fstop_r; // fast clock stop
    logic syssel_r; // system clock select
    logic [1:0] psc_r; // prescaler code
    logic rcstop_r; // rc oscillator stop
    logic ack_r;
    logic [31:0] rdat_r;
    logic slow_sel_nxt;
    logic [1:0] gain_nxt;
    logic pstop_nxt;
    logic fstop_nxt;
    logic syssel_nxt;
    logic [1:0] psc_nxt;
    logic rcstop_nxt;
    logic ack_nxt;
    logic [31:0] rdat_nxt;
    logic req; // new access this cycle
    logic wr_ok; // write to low byte lane
    logic [7:0] wb; // low write byte
    logic [7:0] ctrl_rd; // clock control readback

    // read image of the clock control register
    always_comb begin
        ctrl_rd = {slow_sel_r, gain_r, pstop_r, fstop_r, syssel_r, psc_r};
    end

    // decode, interlocked writes and registered answer
    always_comb begin
        req = cyc_i && stb_i && !ack_r;
        wr_ok = req && we_i && sel_i[0];
        wb = dat_i[7:0];
        slow_sel_nxt = slow_sel_r;
        gain_nxt = gain_r;
        pstop_nxt = pstop_r;
        fstop_nxt = fstop_r;
        syssel_nxt = syssel_r;
        psc_nxt = psc_r;
        rcstop_nxt = rcstop_r;
        ack_nxt = req; // one wait state, single cycle ack
        rdat_nxt = 32'h0000_0000; // unmapped reads return zero
        if (wr_ok && adr_i == AW'(`SCSP_CTRL_ADR)) begin
            // each locked bit tests the value held before this write
            if (syssel_r) begin
                slow_sel_nxt = wb[`SCSP_SLOW_SEL_BIT];
            end
            gain_nxt = wb[`SCSP_GAIN_HI:`SCSP_GAIN_LO];
            pstop_nxt = wb[`SCSP_PSTOP_BIT];
            if (!syssel_r) begin
                fstop_nxt = wb[`SCSP_FSTOP_BIT];
            end
            if (!fstop_r) begin
                syssel_nxt = wb[`SCSP_SYSSEL_BIT];
            end
            psc_nxt = wb[`SCSP_PSC_HI:`SCSP_PSC_LO];
        end
        if (wr_ok && adr_i == AW'(`SCSP_AUX_ADR)) begin
            rcstop_nxt = wb[`SCSP_RCSTOP_BIT];
        end
        if (req && !we_i) begin
            if (adr_i == AW'(`SCSP_CTRL_ADR)) begin
                rdat_nxt = {24'h00_0000, ctrl_rd};
            end else if (adr_i == AW'(`SCSP_AUX_ADR)) begin
                // only the rc stop bit lives here; the rest read zero
                rdat_nxt = {30'h0, rcstop_r, 1'b0};
            end
        end
    end

    // register file flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_sel_r <= 1'(`SCSP_CTRL_RST >> `SCSP_SLOW_SEL_BIT);
            gain_r <= 2'(`SCSP_CTRL_RST >> `SCSP_GAIN_LO);
            pstop_r <= 1'(`SCSP_CTRL_RST >> `SCSP_PSTOP_BIT);
            fstop_r <= 1'(`SCSP_CTRL_RST >> `SCSP_FSTOP_BIT);
            syssel_r <= 1'(`SCSP_CTRL_RST >> `SCSP_SYSSEL_BIT);
            psc_r <= 2'(`SCSP_CTRL_RST);
            rcstop_r <= 1'(`SCSP_AUX_RST >> `SCSP_RCSTOP_BIT);
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            slow_sel_r <= slow_sel_nxt;
            gain_r <= gain_nxt;
            pstop_r <= pstop_nxt;
            fstop_r <= fstop_nxt;
            syssel_r <= syssel_nxt;
            psc_r <= psc_nxt;
            rcstop_r <= rcstop_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ************************************************************
    // source select and prescaler
    // ************************************************************
    logic act_sel_r; // source in use
    logic act_slow_r; // slow source in use
    logic [1:0] act_psc_r; // prescale in use
    logic src_d_r; // selected source one cycle ago
    logic [5:0] cnt_r; // source edges in this half period
    scsp_phase_t ph_r; // output level
    logic act_sel_nxt;
    logic act_slow_nxt;
    logic [1:0] act_psc_nxt;
    logic src_d_nxt;
    logic [5:0] cnt_nxt;
    scsp_phase_t ph_nxt;
    logic [1:0] skip_r; // source edges to ignore after a switch
    logic [1:0] skip_nxt;
    logic src; // selected source level
    logic [5:0] half; // half period limit

    // settings are taken over only as the output falls, so the
    // next low and high phases both come whole from the new source
    always_comb begin
        if (act_sel_r) begin
            src = osc_s2_r[0];
        end else if (act_slow_r) begin
            src = osc_s2_r[2]; // rc oscillator
        end else begin
            src = osc_s2_r[1]; // crystal
        end
        case (scsp_psc_t'(act_psc_r))
            SCSP_DIV64: half = `SCSP_HALF_DIV64;
            SCSP_DIV16: half = `SCSP_HALF_DIV16;
            SCSP_DIV4: half = `SCSP_HALF_DIV4;
            SCSP_DIV1: half = `SCSP_HALF_DIV1;
            default: half = `SCSP_HALF_DIV1;
        endcase
        src_d_nxt = src;
        act_sel_nxt = act_sel_r;
        act_slow_nxt = act_slow_r;
        act_psc_nxt = act_psc_r;
        cnt_nxt = cnt_r;
        ph_nxt = ph_r;
        skip_nxt = skip_r;
        if (src != src_d_r && skip_r != 2'h0) begin
            skip_nxt = skip_r - 2'h1; // edge eaten after a switch
        end else if (src != src_d_r) begin
            if (cnt_r >= half) begin
                cnt_nxt = 6'h00;
                case (ph_r)
                    SCSP_PH_LOW: ph_nxt = SCSP_PH_HIGH;
                    SCSP_PH_HIGH: begin
                        ph_nxt = SCSP_PH_LOW;
                        act_sel_nxt = syssel_r;
                        act_slow_nxt = slow_sel_r;
                        act_psc_nxt = psc_r;
                    end
                    default: ph_nxt = SCSP_PH_LOW;
                endcase
            end else begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
        // a mux change can fake one edge; restart the count after it
        if (ph_r == SCSP_PH_HIGH && ph_nxt == SCSP_PH_LOW &&
            (act_sel_nxt != act_sel_r || act_slow_nxt != act_slow_r)) begin
            src_d_nxt = act_sel_nxt ? osc_s2_r[0]
                      : (act_slow_nxt ? osc_s2_r[2] : osc_s2_r[1]);
            // low phase restarts at a falling edge of the new source,
            // else a near edge would end it after a single clk_i
            skip_nxt = src_d_nxt ? 2'h1 : 2'h2;
        end
    end

    // prescaler flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_sel_r <= 1'b1;
            act_slow_r <= 1'b0;
            act_psc_r <= 2'h3;
            src_d_r <= 1'b0;
            cnt_r <= 6'h00;
            ph_r <= SCSP_PH_LOW;
            skip_r <= 2'h0;
        end else begin
            act_sel_r <= act_sel_nxt;
            act_slow_r <= act_slow_nxt;
            act_psc_r <= act_psc_nxt;
            src_d_r <= src_d_nxt;
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            skip_r <= skip_nxt;
        end
    end

    // ************************************************************
    // gating and output flops
    // ************************************************************
    logic sys_clk_nxt;
    logic periph_en_nxt;
    logic fast_en_nxt;
    logic rc_en_nxt;

    // the fast oscillator is held running until the divider has
    // really left it, so stopping never cuts a fast clock phase
    always_comb begin
        sys_clk_nxt = (ph_nxt == SCSP_PH_HIGH);
        periph_en_nxt = !(pstop_r && idle_i);
        fast_en_nxt = !(fstop_r && (!syssel_r || idle_i) && !act_sel_r);
        rc_en_nxt = !rcstop_r;
    end

    // every output leaves a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_clk_o <= 1'b0;
            periph_clk_en_o <= 1'b1;
            fast_osc_en_o <= 1'b1;
            rc_osc_en_o <= 1'b1;
            crystal_gain_o <= 2'h3;
            slow_source_select_o <= 1'b0;
        end else begin
            sys_clk_o <= sys_clk_nxt;
            periph_clk_en_o <= periph_en_nxt;
            fast_osc_en_o <= fast_en_nxt;
            rc_osc_en_o <= rc_en_nxt;
            crystal_gain_o <= gain_nxt;
            slow_source_select_o <= act_slow_nxt;
        end
    end

    // bus answer flops feed the ports directly
    always_comb begin
        ack_o = ack_r;
        dat_o = rdat_r;
    end

endmodule

/* File: test/scsp_top_asserts.sv */
// assertion checker for the clock control block
`timescale 1ns/1ps
module scsp_chk #(
    parameter int AW = 8 // address width
) (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic we_i, // write
    input wire logic [AW-1:0] adr_i, // address
    input wire logic [3:0] sel_i, // selects
    input wire logic [31:0] dat_i, // write data
    input wire logic [31:0] dat_o, // read data
    input wire logic ack_o, // acknowledge
    input wire logic idle_i, // core idle
    input wire logic sys_clk_o, // system clock
    input wire logic periph_clk_en_o, // peripheral enable
    input wire logic fast_osc_en_o, // fast run
    input wire logic rc_osc_en_o, // rc run
    input wire logic [1:0] crystal_gain_o // gain
);
    // ************************************************************
    // shadow of the control register
    // ************************************************************
    logic tk; // request taken at this edge
    logic wr_c; // taken write to control register
    logic [7:0] shd_r; // shadow value
    logic [7:0] shd_nxt; // shadow next
    assign tk = cyc_i && stb_i && !ack_o;
    assign wr_c = tk && we_i && sel_i[0] && adr_i == AW'(8'hd8);
    // interlocks judged on the value before the write
    always_comb begin
        shd_nxt = shd_r;
        if (wr_c) begin
            shd_nxt = dat_i[7:0];
            if (!shd_r[2]) shd_nxt[7] = shd_r[7];
            if (shd_r[2]) shd_nxt[3] = shd_r[3];
            if (shd_r[3]) shd_nxt[2] = shd_r[2];
        end
    end
    // register only
    always_ff @(posedge clk_i) begin
        shd_r <= rst_i ? 8'h67 : shd_nxt;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_ack_lat: assert property (tk |=> ack_o) else $error("ack not one cycle after request");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
    chk_ctl_read: assert property (ack_o && $past(tk && !we_i && adr_i == AW'(8'hd8))
        |-> dat_o == {24'h0, shd_r}) else $error("control readback wrong");
    chk_gain_follow: assert property (wr_c |=> crystal_gain_o == $past(dat_i[6:5]))
        else $error("gain output wrong");
    chk_rc_run: assert property (tk && we_i && sel_i[0] && adr_i == AW'(8'hf8)
        |=> ##1 rc_osc_en_o == !$past(dat_i[1], 2)) else $error("rc run wrong");
    chk_idle_gate: assert property (periph_clk_en_o == !($past(shd_r[4]) && $past(idle_i)))
        else $error("peripheral enable wrong");
    chk_fast_run: assert property (!shd_r[3] && !$past(shd_r[3]) |-> fast_osc_en_o)
        else $error("fast clock stopped");
    chk_clk_phase: assert property ($changed(sys_clk_o) |=> $stable(sys_clk_o))
        else $error("system clock glitch");
endmodule
bind scsp_top scsp_chk #(.AW(AW)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .idle_i, .sys_clk_o, .periph_clk_en_o, .fast_osc_en_o,
    .rc_osc_en_o, .crystal_gain_o);

/* File: test/tb_scsp_top.sv */
// self-checking bench for the clock control block
`timescale 1ns/1ps
module tb_scsp_top;
    logic clk_i = 1'b0; // clock
    logic rst_i = 1'b1; // reset
    logic cyc_i = 1'b0; // cycle
    logic stb_i = 1'b0; // strobe
    logic we_i = 1'b0; // write
    logic idle_i = 1'b0; // idle
    logic fast_osc_i = 1'b0; // fast pin
    logic xtal_osc_i = 1'b0; // crystal pin
    logic rc_osc_i = 1'b0; // rc pin
    logic [7:0] adr_i = 8'h0; // address
    logic [3:0] sel_i = 4'h0; // selects
    logic [31:0] dat_i = 32'h0; // write data
    logic [31:0] dat_o; // read data
    logic [31:0] rd; // last read
    logic [1:0] crystal_gain_o; // gain
    logic ack_o, sys_clk_o, periph_clk_en_o, fast_osc_en_o, rc_osc_en_o, slow_source_select_o;
    logic [7:0] mdl; // expected control value
    logic [7:0] d; // random data
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'hcbb799e6;
    int n; // measured period
    int oc = 0; // oscillator counter
    scsp_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .idle_i, .fast_osc_i, .xtal_osc_i, .rc_osc_i, .sys_clk_o, .periph_clk_en_o,
        .fast_osc_en_o, .rc_osc_en_o, .crystal_gain_o, .slow_source_select_o);
    initial forever #4 clk_i = ~clk_i;
    // source periods 6, 10 and 8 clocks, slow enough for the synchronisers
    always @(posedge clk_i) begin
        oc <= oc + 1;
        if (oc % 3 == 2) fast_osc_i <= ~fast_osc_i;
        if (oc % 5 == 4) xtal_osc_i <= ~xtal_osc_i;
        if (oc % 4 == 3) rc_osc_i <= ~rc_osc_i;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one classic cycle; ack and read data taken at the edge that sees ack high
    task wb(input logic w, input logic [7:0] a, input logic [7:0] dd, input logic s);
        int t;
        t = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, dd};
        sel_i <= {3'b0, s};
        do begin @(posedge clk_i); t++; end while (ack_o !== 1'b1 && t < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (t >= 50) begin miscompares++; test_done(); end
        @(posedge clk_i);
    endtask
    // blocked interlocked bits keep their old value
    function automatic logic [7:0] nx(input logic [7:0] c, input logic [7:0] w);
        nx = w;
        if (!c[2]) nx[7] = c[7];
        if (c[2]) nx[3] = c[3];
        if (c[3]) nx[2] = c[2];
    endfunction
    task wc(input logic [7:0] w);
        wb(1'b1, 8'hd8, w, 1'b1);
        mdl = nx(mdl, w);
    endtask
    task rdc;
        wb(1'b0, 8'hd8, 8'h0, 1'b1);
        chk("control", {24'h0, mdl}, rd);
    endtask
    task rise;
        n = 0;
        while (sys_clk_o !== 1'b0 && n < 3000) begin @(negedge clk_i); n++; end
        while (sys_clk_o !== 1'b1 && n < 3000) begin @(negedge clk_i); n++; end
        if (n >= 3000) begin miscompares++; test_done(); end
    endtask
    // let a switch land, then time one output period
    task per(input int e);
        repeat (4) rise();
        chk("period", e, n);
        @(posedge clk_i);
    endtask
    initial begin
        mdl = 8'h67;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc();
        wb(1'b0, 8'h10, 8'h0, 1'b1);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 4; i++) begin
            wc(8'h64 | 8'(i));
            per(6 * (64 >> (2 * i)));
        end
        wc(8'h63);
        per(10);
        wc(8'he3);
        wc(8'h7b);
        wc(8'h7f);
        rdc();
        idle_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        chk("fast run", 0, fast_osc_en_o);
        chk("periph", 0, periph_clk_en_o);
        @(posedge clk_i);
        idle_i <= 1'b0;
        wc(8'h63);
        wc(8'h67);
        wc(8'h6f);
        wb(1'b1, 8'hf8, 8'hff, 1'b1);
        chk("rc run", 0, rc_osc_en_o);
        wb(1'b0, 8'hf8, 8'h0, 1'b1);
        chk("aux", 32'h2, rd);
        wb(1'b1, 8'hf8, 8'h0, 1'b0);
        chk("rc hold", 0, rc_osc_en_o);
        wb(1'b1, 8'hf8, 8'h0, 1'b1);
        chk("rc restart", 1, rc_osc_en_o);
        wc(8'he7);
        wc(8'he3);
        per(8);
        chk("source", 1, slow_source_select_o);
        for (int i = 0; i < 40; i++) begin
            d = 8'($random(seed));
            idle_i <= 1'($random(seed));
            wb(1'b1, 8'hd8, d, 1'(i % 5 != 0));
            if (i % 5 != 0) mdl = nx(mdl, d);
            chk("gain", mdl[6:5], crystal_gain_o);
            rdc();
        end
        test_done();
    end
endmodule
